//--- logic/alu_defs.svh
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DATA_W       32
`define AMT_W        8
`define SHIFT_IMM_W  5

// ----------------------------------------------------------------
// status register layout
// ----------------------------------------------------------------
`define FLAG_NEG     31
`define FLAG_ZERO    30
`define FLAG_CARRY   29
`define FLAG_OVF     28
`define SIGN_BIT     31
`define STATUS_RESET 32'h0000_0000

// ----------------------------------------------------------------
// shifter limits
// ----------------------------------------------------------------
`define SHIFT_LIMIT  8'h20
`define AMT_ZERO     8'h00
`define ROT_ZERO     5'h00

`endif

//--- logic/alu_pkg.sv
`include "alu_defs.svh"

package alu_pkg;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_add,
    op_subtract,
    reversed_subtract,
    sum_with_carry,
    difference_with_borrow,
    reversed_subtract_borrow,
    copy_operand,
    copy_inverted,
    bit_and,
    inclusive_or,
    exclusive_or,
    or_not,
    mask_clear,
    compare_flags_only,
    compare_negated,
    test_bits,
    test_equivalence
  } alu_op_type;

  typedef enum logic [2:0] {
    logical_left,
    logical_right,
    arithmetic_right,
    rotate_right,
    rotate_through_carry
  } shift_kind_type;

  typedef enum logic [1:0] {
    op2_immediate,
    op2_register,
    op2_reg_shift_imm,
    op2_reg_shift_reg
  } op2_src_type;

  // ----------------------------------------------------------------
  // request and state carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    alu_op_type                 op;
    logic                       flag_write_option;
    op2_src_type                op2_src;
    shift_kind_type             shift_kind;
    logic [`SHIFT_IMM_W-1:0]    shift_imm;
    logic [`DATA_W-1:0]         rn_value;
    logic [`DATA_W-1:0]         imm_value;
    logic [`DATA_W-1:0]         rm_value;
    logic [`DATA_W-1:0]         rs_value;
  } request_type;

  typedef struct packed {
    logic [`DATA_W-1:0]         status;
    logic [`DATA_W-1:0]         result;
    logic                       result_write;
    logic                       result_valid;
    logic                       flags_upd;
  } state_type;

endpackage

//--- logic/barrel_shifter.sv
`timescale 1ns/1ps
`include "alu_defs.svh"

module barrel_shifter
(
  input  wire logic [`DATA_W-1:0]   shift_in,
  input  wire logic [`AMT_W-1:0]    amount,
  input  wire alu_pkg::shift_kind_type kind,
  input  wire logic                 carry_in,
  output logic [`DATA_W-1:0]        shift_out,
  output logic                      carry_out
);
  import alu_pkg::*;

  logic [2*`DATA_W-1:0]        wide;
  logic signed [2*`DATA_W-1:0] swide;

  always_comb
  begin
    wide      = '0;
    swide     = '0;
    shift_out = shift_in;
    carry_out = carry_in;
    case (kind)
      logical_left:
      begin
        if (amount == `AMT_ZERO)
        begin
          shift_out = shift_in;
          carry_out = carry_in;
        end
        else if (amount <= `SHIFT_LIMIT)
        begin
          wide      = {{`DATA_W{1'b0}}, shift_in} << amount;
          shift_out = wide[`DATA_W-1:0];
          carry_out = wide[`DATA_W];
        end
        else
        begin
          shift_out = '0;
          carry_out = 1'b0;
        end
      end
      logical_right:
      begin
        if (amount == `AMT_ZERO)
        begin
          shift_out = shift_in;
          carry_out = carry_in;
        end
        else if (amount <= `SHIFT_LIMIT)
        begin
          wide      = {shift_in, {`DATA_W{1'b0}}} >> amount;
          shift_out = wide[2*`DATA_W-1:`DATA_W];
          carry_out = wide[`DATA_W-1];
        end
        else
        begin
          shift_out = '0;
          carry_out = 1'b0;
        end
      end
      arithmetic_right:
      begin
        if (amount == `AMT_ZERO)
        begin
          shift_out = shift_in;
          carry_out = carry_in;
        end
        else if (amount < `SHIFT_LIMIT)
        begin
          swide     = $signed({shift_in, {`DATA_W{1'b0}}}) >>> amount;
          shift_out = swide[2*`DATA_W-1:`DATA_W];
          carry_out = swide[`DATA_W-1];
        end
        else
        begin
          shift_out = {`DATA_W{shift_in[`SIGN_BIT]}};
          carry_out = shift_in[`SIGN_BIT];
        end
      end
      rotate_right:
      begin
        if (amount == `AMT_ZERO)
        begin
          shift_out = shift_in;
          carry_out = carry_in;
        end
        else if (amount[`SHIFT_IMM_W-1:0] == `ROT_ZERO)
        begin
          shift_out = shift_in;
          carry_out = shift_in[`SIGN_BIT];
        end
        else
        begin
          wide      = {shift_in, shift_in} >> amount[`SHIFT_IMM_W-1:0];
          shift_out = wide[`DATA_W-1:0];
          carry_out = wide[`SIGN_BIT];
        end
      end
      rotate_through_carry:
      begin
        shift_out = {carry_in, shift_in[`DATA_W-1:1]};
        carry_out = shift_in[0];
      end
      default:
      begin
        shift_out = shift_in;
        carry_out = carry_in;
      end
    endcase
  end

endmodule // barrel_shifter

//--- logic/alu_flags_shifter_datapath.sv
`timescale 1ns/1ps
`include "alu_defs.svh"

// Overview of operation
// - flag-setting operations copy result bit 31 into status bit 31.
// - flag-setting operations set status bit 30 when the result is zero.
// - status bit 29 takes adder carry, or shifter carry for shift-sourced results.
// - status bit 28 is set on signed overflow or underflow of arithmetic operations, else cleared; logic operations keep it.
// - signed overflow is a wrong sign change from bit 30 into bit 31.
// - carry flag is set when the unsigned result exceeds 32 bits.
// - ordinary operations change flags only with the flag write option.
// - add, subtract and reversed subtract write one destination value.
// - carry forms add carry, or subtract inverted carry, normal or reversed.
// - copy and copy-inverted write the second operand, ignoring the first.
// - and, or, xor, or-not, and mask clear as first and not second.
// - compare and test operations update flags and never write a destination.
// - compares act as subtract and add, tests as and and xor.
// - first operand is a register; second is immediate, register or shifted register.
// - shifter offers left, logical right, arithmetic right, rotate, rotate through carry.
// - logical right fills zeros; arithmetic right fills copies of bit 31.
// - left shifts always insert zeros at the bottom.
// - every operation, copy included, may take a shifted second operand.

module alu_flags_shifter_datapath
(
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 req_valid,
  input  wire alu_pkg::request_type req,
  input  wire logic                 status_wr_en,
  input  wire logic [`DATA_W-1:0]   status_wr_data,
  output logic [`DATA_W-1:0]        result_data,
  output logic                      result_write,
  output logic                      result_valid,
  output logic                      flags_updated,
  output logic [`DATA_W-1:0]        status_value
);
  import alu_pkg::*;

  // ----------------------------------------------------------------
  // second operand selection
  // ----------------------------------------------------------------
  state_type            st_q;
  state_type            st_d;
  logic [`DATA_W-1:0]   op2;
  logic [`DATA_W-1:0]   shifted;
  logic                 shift_carry;
  logic                 op2_carry;
  logic [`AMT_W-1:0]    shift_amount;
  logic                 carry_flag;

  assign carry_flag = st_q.status[`FLAG_CARRY];

  // register amount takes the low byte of the amount register
  assign shift_amount = (req.op2_src == op2_reg_shift_reg) ?
                        req.rs_value[`AMT_W-1:0] :
                        {{(`AMT_W-`SHIFT_IMM_W){1'b0}}, req.shift_imm};

  barrel_shifter u_shifter
  (
    .shift_in  (req.rm_value),
    .amount    (shift_amount),
    .kind      (req.shift_kind),
    .carry_in  (carry_flag),
    .shift_out (shifted),
    .carry_out (shift_carry)
  );

  always_comb
  begin
    op2       = req.rm_value;
    op2_carry = carry_flag;
    case (req.op2_src)
      op2_immediate:
      begin
        op2       = req.imm_value;
        op2_carry = carry_flag;
      end
      op2_register:
      begin
        op2       = req.rm_value;
        op2_carry = carry_flag;
      end
      op2_reg_shift_imm,
      op2_reg_shift_reg:
      begin
        op2       = shifted;
        op2_carry = shift_carry;
      end
      default:
      begin
        op2       = req.rm_value;
        op2_carry = carry_flag;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // adder
  // ----------------------------------------------------------------
  logic [`DATA_W-1:0]   add_a;
  logic [`DATA_W-1:0]   add_b;
  logic                 add_cin;
  logic [`DATA_W:0]     add_sum;
  logic                 add_ovf;
  logic                 is_arith;
  logic                 is_compare;

  always_comb
  begin
    add_a    = req.rn_value;
    add_b    = op2;
    add_cin  = 1'b0;
    is_arith = 1'b1;
    case (req.op)
      op_add,
      compare_negated:
      begin
        add_b   = op2;
        add_cin = 1'b0;
      end
      sum_with_carry:
      begin
        add_b   = op2;
        add_cin = carry_flag;
      end
      op_subtract,
      compare_flags_only:
      begin
        add_b   = ~op2;
        add_cin = 1'b1;
      end
      difference_with_borrow:
      begin
        add_b   = ~op2;
        add_cin = carry_flag;
      end
      reversed_subtract:
      begin
        add_a   = op2;
        add_b   = ~req.rn_value;
        add_cin = 1'b1;
      end
      reversed_subtract_borrow:
      begin
        add_a   = op2;
        add_b   = ~req.rn_value;
        add_cin = carry_flag;
      end
      default:
      begin
        is_arith = 1'b0;
      end
    endcase
  end

  assign add_sum = {1'b0, add_a} + {1'b0, add_b} + {{`DATA_W{1'b0}}, add_cin};
  // sign flips only when both addends agree in sign and the sum does not
  assign add_ovf = (add_a[`SIGN_BIT] == add_b[`SIGN_BIT]) &&
                   (add_sum[`SIGN_BIT] != add_a[`SIGN_BIT]);

  assign is_compare = (req.op == compare_flags_only) || (req.op == compare_negated) ||
                      (req.op == test_bits) || (req.op == test_equivalence);

  // ----------------------------------------------------------------
  // logic unit and state update
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [`DATA_W-1:0] value;
    value              = add_sum[`DATA_W-1:0];
    st_d               = st_q;
    st_d.result_write  = 1'b0;
    st_d.result_valid  = 1'b0;
    st_d.flags_upd     = 1'b0;
    case (req.op)
      copy_operand:     value = op2;
      copy_inverted:    value = ~op2;
      bit_and,
      test_bits:        value = req.rn_value & op2;
      inclusive_or:     value = req.rn_value | op2;
      exclusive_or,
      test_equivalence: value = req.rn_value ^ op2;
      or_not:           value = req.rn_value | ~op2;
      mask_clear:       value = req.rn_value & ~op2;
      default:          value = add_sum[`DATA_W-1:0];
    endcase
    if (status_wr_en)
    begin
      st_d.status = status_wr_data;
    end
    if (req_valid)
    begin
      st_d.result_valid = 1'b1;
      st_d.result       = value;
      st_d.result_write = !is_compare;
      if (req.flag_write_option || is_compare)
      begin
        st_d.flags_upd                 = 1'b1;
        st_d.status[`FLAG_NEG]         = value[`SIGN_BIT];
        st_d.status[`FLAG_ZERO]        = (value == '0);
        if (is_arith)
        begin
          st_d.status[`FLAG_CARRY]     = add_sum[`DATA_W];
          st_d.status[`FLAG_OVF]       = add_ovf;
        end
        else
        begin
          st_d.status[`FLAG_CARRY]     = op2_carry;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= '{status: `STATUS_RESET, result: '0, result_write: 1'b0,
                result_valid: 1'b0, flags_upd: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign result_data   = st_q.result;
  assign result_write  = st_q.result_write;
  assign result_valid  = st_q.result_valid;
  assign flags_updated = st_q.flags_upd;
  assign status_value  = st_q.status;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [`DATA_W:0]   ref_add;
  assign ref_add = {1'b0, req.rn_value} + {1'b0, op2};

  neg_flag_a: assert property (flags_updated |-> status_value[31] == result_data[31])
    else $error("negative flag differs from result top bit");

  zero_flag_a: assert property (flags_updated |-> status_value[30] == (result_data == 0))
    else $error("zero flag wrong");

  add_carry_a: assert property (req_valid && req.op == op_add
    && req.flag_write_option |=> flags_updated && status_value[29] == $past(ref_add[32]))
    else $error("carry flag does not match unsigned add overflow");

  add_overflow_a: assert property (req_valid && req.op == op_add
    && req.flag_write_option |=> status_value[28] ==
    ($past(req.rn_value[31]) == $past(op2[31]) && result_data[31] != $past(req.rn_value[31])))
    else $error("overflow flag wrong for add");

  logic_carry_a: assert property (req_valid && req.op == copy_operand
    && req.flag_write_option && req.op2_src == op2_reg_shift_imm
    && req.shift_kind == logical_left && req.shift_imm != 0
    |=> status_value[29] == $past(req.rm_value[32 - req.shift_imm]))
    else $error("carry flag is not the last bit shifted out");

  flags_hold_a: assert property (req_valid && !req.flag_write_option && !is_compare
    && !status_wr_en |=> $stable(status_value) && !flags_updated)
    else $error("flags changed without flag write option");

  compare_write_a: assert property (req_valid && is_compare
    |=> !result_write && flags_updated)
    else $error("compare or test wrote a destination");

  rsb_value_a: assert property (req_valid && req.op == reversed_subtract
    |=> result_write && result_data == $past(op2) - $past(req.rn_value))
    else $error("reversed subtract result wrong");

  borrow_value_a: assert property (req_valid && req.op == difference_with_borrow
    |=> result_data == $past(req.rn_value) - $past(op2) - {31'h0, !$past(carry_flag)})
    else $error("subtract with borrow result wrong");

  mask_clear_a: assert property (req_valid && req.op == mask_clear
    |=> result_data == ($past(req.rn_value) & ~$past(op2)))
    else $error("mask clear result wrong");

  copy_value_a: assert property (req_valid && req.op == copy_inverted
    |=> result_data == ~$past(op2))
    else $error("copy inverted result wrong");

  asr_fill_a: assert property (req.op2_src == op2_reg_shift_reg
    && req.shift_kind == arithmetic_right && req.rs_value[7:0] >= 8'h20
    |-> op2 == {32{req.rm_value[31]}})
    else $error("arithmetic right fill wrong");

  rrx_shape_a: assert property (req.op2_src == op2_reg_shift_imm
    && req.shift_kind == rotate_through_carry
    |-> op2 == {carry_flag, req.rm_value[31:1]} && op2_carry == req.rm_value[0])
    else $error("rotate through carry wrong");

  one_cycle_a: assert property (req_valid
    |=> result_valid ##1 (!result_valid || $past(req_valid)))
    else $error("result not registered one cycle after request");

  lsr_fill_a: assert property (req.op2_src == op2_reg_shift_reg
    && req.shift_kind == logical_right && req.rs_value[`AMT_W-1:0] == `SHIFT_LIMIT
    |-> op2 == '0 && op2_carry == req.rm_value[`SIGN_BIT])
    else $error("logical right by full width wrong");

  lsl_fill_a: assert property (req.op2_src == op2_reg_shift_imm
    && req.shift_kind == logical_left
    |-> (op2 & ~({`DATA_W{1'b1}} << req.shift_imm)) == '0)
    else $error("left shift did not insert zeros");

  ror_value_a: assert property (req.op2_src == op2_reg_shift_reg
    && req.shift_kind == rotate_right && req.rs_value[`SHIFT_IMM_W-1:0] != `ROT_ZERO
    |-> op2 == ((req.rm_value >> req.rs_value[`SHIFT_IMM_W-1:0]) |
                (req.rm_value << (`DATA_W - req.rs_value[`SHIFT_IMM_W-1:0]))))
    else $error("rotate right result wrong");

  copy_pass_a: assert property (req_valid && req.op == copy_operand
    |=> result_write && result_data == $past(op2))
    else $error("copy result wrong");

  carry_add_a: assert property (req_valid && req.op == sum_with_carry
    |=> result_data == $past(req.rn_value) + $past(op2) + {31'h0, $past(carry_flag)})
    else $error("add with carry result wrong");

  rsc_value_a: assert property (req_valid && req.op == reversed_subtract_borrow
    |=> result_data == $past(op2) - $past(req.rn_value) - {31'h0, !$past(carry_flag)})
    else $error("reversed subtract with borrow result wrong");

  sub_overflow_a: assert property (req_valid && req.op == op_subtract
    && req.flag_write_option |=> flags_updated && status_value[`FLAG_OVF] ==
    ($past(req.rn_value[`SIGN_BIT]) != $past(op2[`SIGN_BIT]) &&
     result_data[`SIGN_BIT] != $past(req.rn_value[`SIGN_BIT])))
    else $error("overflow flag wrong for subtract");

  cmn_carry_a: assert property (req_valid && req.op == compare_negated
    |=> flags_updated && status_value[`FLAG_CARRY] == $past(ref_add[`DATA_W]))
    else $error("compare negated carry wrong");

  teq_value_a: assert property (req_valid && req.op == test_equivalence
    |=> !result_write && result_data == ($past(req.rn_value) ^ $past(op2)))
    else $error("test equivalence value wrong");

endmodule // alu_flags_shifter_datapath

//--- test/regfile_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// register file write port seen from the datapath
// ----------------------------------------------------------------
module regfile_model
(
  input  wire logic        core_clk,
  input  wire logic        result_write,
  input  wire logic [31:0] result_data,
  output logic      [31:0] last_written,
  output logic      [15:0] write_count
);
  initial
  begin
    last_written = 32'h0000_0000;
    write_count  = 16'h0000;
  end

  // destination written only on a write strobe
  always @(posedge core_clk)
  begin
    if (result_write === 1'b1)
    begin
      last_written <= result_data;
      write_count  <= write_count + 16'h0001;
    end
  end
endmodule // regfile_model

//--- test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import alu_pkg::*;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic        fl;
    logic [31:0] res;
    logic [31:0] st;
  } exp_type;

  logic        core_clk;
  logic        sys_rst;
  logic        req_valid;
  request_type req_in;
  logic        status_wr_en;
  logic [31:0] status_wr_data;
  logic [31:0] result_data;
  logic        result_write;
  logic        result_valid;
  logic        flags_updated;
  logic [31:0] status_value;
  logic [31:0] last_written;
  logic [15:0] write_count;
  integer      seed;
  integer      mismatches;
  integer      compares;
  integer      writes;
  integer      i;
  integer      k;
  logic [31:0] last_wr;
  logic [7:0]  amts [6];
  logic [159:0] raw;
  exp_type     pend;
  request_type r;

  alu_flags_shifter_datapath i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req_in), .status_wr_en(status_wr_en),
    .status_wr_data(status_wr_data), .result_data(result_data),
    .result_write(result_write), .result_valid(result_valid),
    .flags_updated(flags_updated), .status_value(status_value));

  regfile_model i_regfile (.core_clk(core_clk), .result_write(result_write),
    .result_data(result_data), .last_written(last_written), .write_count(write_count));

  always #25 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // expected outcome of one cycle
  // ----------------------------------------------------------------
  function automatic exp_type predict(request_type q, logic [31:0] st, logic v, logic we,
                                      logic [31:0] wd);
    logic [31:0] a, b, sv, res, x, y;
    logic [7:0]  amt;
    logic [32:0] t;
    logic        sc, vf, ci, arith, cmp;
    exp_type     e;
    a   = q.rn_value;
    vf  = we ? wd[28] : st[28];
    sv  = (q.op2_src == op2_immediate) ? q.imm_value : q.rm_value;
    amt = (q.op2_src == op2_reg_shift_reg) ? q.rs_value[7:0] :
          (q.op2_src == op2_reg_shift_imm) ? {3'h0, q.shift_imm} : 8'h00;
    b   = sv;
    sc  = st[29];
    if (q.op2_src inside {op2_reg_shift_imm, op2_reg_shift_reg})
    begin
      if (q.shift_kind == rotate_through_carry)
        {b, sc} = {st[29], sv};
      else if (amt != 8'h00)
        case (q.shift_kind)
          logical_left:     {sc, b} = {1'b0, sv} << amt;
          logical_right:    {b, sc} = {sv, 1'b0} >> amt;
          arithmetic_right: {b, sc} = $signed({sv, 1'b0}) >>> amt;
          default:          {sc, b} = {sv[amt[4:0] - 5'h1],
                                       (sv >> amt[4:0]) | (sv << (6'h20 - amt[4:0]))};
        endcase
    end
    {arith, x, y, ci} = {1'b0, 65'h0};
    case (q.op)
      op_add, compare_negated:           {arith, x, y, ci} = {1'b1, a, b, 1'b0};
      op_subtract, compare_flags_only:   {arith, x, y, ci} = {1'b1, a, ~b, 1'b1};
      reversed_subtract:                 {arith, x, y, ci} = {1'b1, b, ~a, 1'b1};
      sum_with_carry:                    {arith, x, y, ci} = {1'b1, a, b, st[29]};
      difference_with_borrow:            {arith, x, y, ci} = {1'b1, a, ~b, st[29]};
      reversed_subtract_borrow:          {arith, x, y, ci} = {1'b1, b, ~a, st[29]};
      default:                           arith = 1'b0;
    endcase
    case (q.op)
      copy_operand:                 res = b;
      copy_inverted:                res = ~b;
      bit_and, test_bits:           res = a & b;
      inclusive_or:                 res = a | b;
      exclusive_or, test_equivalence: res = a ^ b;
      or_not:                       res = a | ~b;
      default:                      res = a & ~b;
    endcase
    if (arith)
    begin
      t   = {1'b0, x} + {1'b0, y} + {32'h0, ci};
      res = t[31:0];
      sc  = t[32];
      vf  = (x[31] == y[31]) && (res[31] != x[31]);
    end
    cmp     = q.op inside {compare_flags_only, compare_negated, test_bits, test_equivalence};
    e.valid = v;
    e.wr    = v && !cmp;
    e.fl    = v && (cmp || q.flag_write_option);
    e.res   = res;
    e.st    = we ? wd : st;
    if (e.fl)
      e.st[31:28] = {res[31], res == 32'h0, sc, vf};
    return e;
  endfunction

  // ----------------------------------------------------------------
  // comparison, drive and reset tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expct);
    compares = compares + 1;
    if (seen !== expct)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expct);
      mismatches = mismatches + 1;
    end
  endtask

  task automatic run_op(input logic v, input logic we, input logic [31:0] wd);
    exp_type nxt;
    @(posedge core_clk);
    req_valid      <= v;
    req_in         <= r;
    status_wr_en   <= we;
    status_wr_data <= wd;
    nxt = predict(r, pend.st, v, we, wd);
    @(negedge core_clk);
    check(status_value, pend.st);
    check({31'h0, result_valid}, {31'h0, pend.valid});
    check({31'h0, result_write}, {31'h0, pend.wr});
    check({31'h0, flags_updated}, {31'h0, pend.fl});
    if (pend.valid)
      check(result_data, pend.res);
    if (pend.wr)
    begin
      writes  = writes + 1;
      last_wr = pend.res;
    end
    pend = nxt;
  endtask

  task automatic do_reset(input integer n);
    @(posedge core_clk);
    sys_rst      <= 1'b1;
    req_valid    <= 1'b0;
    status_wr_en <= 1'b0;
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
    check(status_value, 32'h0000_0000);
    check({31'h0, result_valid}, 32'h0000_0000);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    pend = '0;
  endtask

  task automatic set_req(input alu_op_type op, input op2_src_type src,
                         input shift_kind_type kind, input logic [31:0] rn,
                         input logic [31:0] rm, input logic [7:0] amt);
    r = {op, 1'b1, src, kind, amt[4:0], rn, rm, rm, 24'h0, amt};
  endtask

  task automatic rand_req();
    raw = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    r            = raw[143:0];
    r.op         = alu_op_type'(5'($unsigned($random(seed)) % 17));
    r.shift_kind = shift_kind_type'(3'($unsigned($random(seed)) % 5));
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    #250000;
    mismatches = mismatches + 1;
    tally_and_finish();
  end

  initial
  begin
    {core_clk, sys_rst, req_valid, status_wr_en} = 4'h4;
    {req_in, status_wr_data, r} = '0;
    {mismatches, compares, writes, last_wr, pend} = '0;
    seed = 98136;
    amts = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'hff};
    do_reset(12);
    $display("test reset done");
    set_req(op_add, op2_register, logical_left, 32'h7fff_ffff, 32'h0000_0002, 8'h00);
    run_op(1'b1, 1'b0, 32'h0);
    run_op(1'b0, 1'b0, 32'h0);
    check(result_data, 32'h8000_0001);
    check(status_value, 32'h9000_0000);
    r.flag_write_option = 1'b0;
    run_op(1'b1, 1'b0, 32'h0);
    set_req(compare_flags_only, op2_immediate, logical_left, 32'h5, 32'h5, 8'h00);
    run_op(1'b1, 1'b0, 32'h0);
    $display("test walk done");
    for (i = 0; i < 34; i++)
    begin
      rand_req();
      r.op = alu_op_type'(5'(i % 17));
      r.flag_write_option = (i >= 17);
      run_op(1'b1, 1'b0, 32'h0);
    end
    set_req(op_add, op2_immediate, logical_left, 32'hffff_ffff, 32'h1, 8'h00);
    run_op(1'b1, 1'b0, 32'h0);
    set_req(sum_with_carry, op2_immediate, logical_left, 32'h0, 32'h0, 8'h00);
    run_op(1'b1, 1'b0, 32'h0);
    set_req(difference_with_borrow, op2_immediate, logical_left, 32'h0, 32'h1, 8'h00);
    run_op(1'b1, 1'b0, 32'h0);
    set_req(reversed_subtract_borrow, op2_immediate, logical_left, 32'h1, 32'h0, 8'h00);
    run_op(1'b1, 1'b0, 32'h0);
    $display("test ops and chaining done");
    for (k = 0; k < 5; k++)
      for (i = 0; i < 12; i++)
      begin
        set_req(copy_operand, (i < 6) ? op2_reg_shift_reg : op2_reg_shift_imm,
                shift_kind_type'(3'(k)), $random(seed), 32'h8000_0001 ^ (i << 4), amts[i % 6]);
        run_op(1'b1, 1'b0, 32'h0);
      end
    $display("test shifter done");
    run_op(1'b0, 1'b1, 32'h5a5a_5a5a);
    set_req(test_bits, op2_immediate, logical_left, 32'h0, 32'h0, 8'h00);
    run_op(1'b1, 1'b1, 32'h0f0f_f0f0);
    $display("test status write done");
    repeat (400)
    begin
      rand_req();
      run_op(($unsigned($random(seed)) % 5) != 0, ($unsigned($random(seed)) % 8) == 0,
             $random(seed));
    end
    $display("test random done");
    do_reset(2);
    repeat (20)
    begin
      rand_req();
      run_op(1'b1, 1'b0, 32'h0);
    end
    run_op(1'b0, 1'b0, 32'h0);
    run_op(1'b0, 1'b0, 32'h0);
    check({16'h0, write_count}, writes);
    check(last_written, last_wr);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule // tb_top
